// >>> verilog/lep_defines.vh
// Constants for the latched memory port host controller
// Overview of operation
// R1: Device decodes seven modes from enables, strobe/supply, high-volt line, id select.
// R2: Device latches low address byte; latched value addresses the array.
// R3: Host presents low address before latch closes, then reuses lines for data.
// R4: Device drives byte lines only with both enables low; else high impedance. Verify reads with chip enable high; the model drives then.
// R5: Array is 32K locations of eight bits; each read returns one byte.
// R6: Controller may program locations singly, in blocks, or in any order.
// R7: Identification needs high-volt line raised with both enables low.
// R8: Strobe pin carries programming supply in program, verify, inhibit modes.
// R9: Programming takes data with chip enable low, output enable high.
// R10: Latch closes on strobe fall and opens on strobe rise.
// R11: Id select low gives maker byte, high gives device byte; odd parity.
// R12: Chip enable high powers down the device; outputs high impedance. Verify holds chip enable high with supply on; outputs driven.
// R13: Latch is transparent while programming; all address lines select.
// R14: Host drops strobe after low address stable; turns lines after edge. The host drops strobe for reads only; program, verify and id keep it high.
`ifndef LEP_DEFINES_VH
`define LEP_DEFINES_VH
`define LEP_CLK_NS 8
`define LEP_ACC_NS 250
`define LEP_ACC_CYC ((`LEP_ACC_NS + `LEP_CLK_NS - 1) / `LEP_CLK_NS)
`define LEP_SU_NS 80
`define LEP_SU_CYC ((`LEP_SU_NS + `LEP_CLK_NS - 1) / `LEP_CLK_NS)
`define LEP_PULSE_US 100
`define LEP_PULSE_CYC (`LEP_PULSE_US * 1000 / `LEP_CLK_NS)
`define LEP_CNT_W 14
`define LEP_OP_READ 2'h0
`define LEP_OP_PROG 2'h1
`define LEP_OP_VERIFY 2'h2
`define LEP_OP_IDENT 2'h3
`endif

// >>> verilog/lep_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module lep_sync #(
  parameter W = 8
) (
  input wire mclk,
  input wire sys_rst,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;
  always @(posedge mclk) begin
    if (sys_rst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Each bit changes only once stages two and three agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // lep_sync
`default_nettype wire

// >>> verilog/lep_host.v
// Host controller driving the latched one-time programmable memory pins
`timescale 1ns/1ps
`default_nettype none
`include "lep_defines.vh"
module lep_host #(
  parameter PULSE_CYC = `LEP_PULSE_CYC
) (
  input wire mclk,
  input wire sys_rst,
  input wire req_valid,
  output wire req_ready,
  input wire [1:0] req_op,
  input wire [14:0] req_addr,
  input wire [7:0] req_wdata,
  output reg rsp_valid,
  output reg [7:0] rsp_rdata,
  output reg chip_en_n,
  output reg out_en_n,
  output reg latch_strobe,
  output reg prog_supply_en,
  output reg id_select_high_volt_line,
  output reg [14:8] address_hi,
  output reg [7:0] byte_lines_o,
  output reg byte_lines_oe,
  input wire [7:0] byte_lines_i
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_LATCH = 3'h2;
  localparam ST_ACCESS = 3'h3;
  localparam ST_PULSE = 3'h4;
  localparam ST_DONE = 3'h5;

  // ------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------
  // Loads are sized to the counter so no assignment drops bits
  localparam [`LEP_CNT_W-1:0] SU_LOAD = `LEP_SU_CYC;
  localparam [`LEP_CNT_W-1:0] ACC_LOAD = `LEP_ACC_CYC;
  // A pulse count beyond the counter's reach would wrap; the default
  // of one hundred microseconds still fits
  localparam [`LEP_CNT_W-1:0] PULSE_LOAD = PULSE_CYC;

  reg [2:0] st_r;
  reg [`LEP_CNT_W-1:0] cnt_r;
  reg [1:0] op_r;
  reg [7:0] wdata_r;
  wire [7:0] rd_sync;

  lep_sync #(.W(8)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(byte_lines_i),
    .dout(rd_sync)
  );

  assign req_ready = (st_r == ST_IDLE);
  wire take = req_valid && req_ready;
  wire cnt_zero = (cnt_r == {`LEP_CNT_W{1'b0}});

  // ------------------------------------------------------------
  // Address presented on the pins
  // ------------------------------------------------------------
  // R11 identification holds every line low but the byte select
  wire is_ident = (req_op == `LEP_OP_IDENT);
  wire [6:0] hi_pick = is_ident ? 7'h00 : req_addr[14:8];
  wire [7:0] lo_pick = is_ident ? {7'h00, req_addr[0]} : req_addr[7:0];
  // R8 program and verify put the supply on the strobe pin
  wire needs_supply = (req_op == `LEP_OP_PROG) ||
                      (req_op == `LEP_OP_VERIFY);

  // ------------------------------------------------------------
  // Request capture
  // ------------------------------------------------------------
  // Captured once per request so a later change on the request
  // lines cannot alter an operation in flight
  always @(posedge mclk) begin
    if (sys_rst) begin
      op_r <= `LEP_OP_READ;
      wdata_r <= 8'h00;
    end else if (take) begin
      // R6 any address order
      op_r <= req_op;
      wdata_r <= req_wdata;
    end
  end

  // ------------------------------------------------------------
  // Response
  // ------------------------------------------------------------
  // A read ends when the access count runs out; a program ends when
  // the pulse count runs out with chip enable still low
  wire read_end = (st_r == ST_ACCESS) && cnt_zero;
  wire prog_end = (st_r == ST_PULSE) && cnt_zero && !chip_en_n;

  always @(posedge mclk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      // One-cycle pulse; the byte stays until the next answer
      rsp_valid <= read_end || prog_end;
      if (read_end) begin
        // Synchroniser lag: the byte settled a few cycles earlier
        rsp_rdata <= rd_sync;
      end else if (prog_end) begin
        rsp_rdata <= wdata_r;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      cnt_r <= {`LEP_CNT_W{1'b0}};
      chip_en_n <= 1'b1;
      out_en_n <= 1'b1;
      latch_strobe <= 1'b1;
      prog_supply_en <= 1'b0;
      id_select_high_volt_line <= 1'b0;
      address_hi <= 7'h00;
      byte_lines_o <= 8'h00;
      byte_lines_oe <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          // R12 power down
          chip_en_n <= 1'b1;
          out_en_n <= 1'b1;
          latch_strobe <= 1'b1;
          prog_supply_en <= 1'b0;
          id_select_high_volt_line <= 1'b0;
          byte_lines_oe <= 1'b0;
          if (req_valid) begin
            address_hi <= hi_pick;
            byte_lines_o <= lo_pick;
            // R3 shared lines carry address
            byte_lines_oe <= 1'b1;
            cnt_r <= SU_LOAD;
            st_r <= ST_ADDR;
            if (is_ident) begin
              // R7 high volt line
              id_select_high_volt_line <= 1'b1;
            end
            // R8 supply replaces strobe
            if (needs_supply) begin
              prog_supply_en <= 1'b1;
            end
          end
        end
        ST_ADDR: begin
          if (cnt_r != {`LEP_CNT_W{1'b0}}) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            // R14 strobe after address stable
            if (op_r == `LEP_OP_READ) begin
              // R10 strobe fall captures
              latch_strobe <= 1'b0;
            end
            st_r <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          cnt_r <= ACC_LOAD;
          if (op_r == `LEP_OP_PROG) begin
            // R9 R13 data in, latch transparent
            // Limitation: with shared lines the data byte is also the
            // low address of the location being programmed
            byte_lines_o <= wdata_r;
            chip_en_n <= 1'b1;
            out_en_n <= 1'b1;
            cnt_r <= SU_LOAD;
            st_r <= ST_PULSE;
          end else begin
            // R3 release lines after edge; R4 device drives
            byte_lines_oe <= 1'b0;
            out_en_n <= 1'b0;
            // Verify reads with chip enable high
            chip_en_n <= (op_r == `LEP_OP_VERIFY);
            st_r <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (cnt_r != {`LEP_CNT_W{1'b0}}) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            st_r <= ST_DONE;
          end
        end
        ST_PULSE: begin
          if (cnt_r != {`LEP_CNT_W{1'b0}}) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (chip_en_n) begin
            chip_en_n <= 1'b0;
            cnt_r <= PULSE_LOAD;
          end else begin
            chip_en_n <= 1'b1;
            st_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Strobe rise reopens the latch
          latch_strobe <= 1'b1;
          chip_en_n <= 1'b1;
          out_en_n <= 1'b1;
          byte_lines_oe <= 1'b0;
          prog_supply_en <= 1'b0;
          id_select_high_volt_line <= 1'b0;
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // lep_host
`default_nettype wire

// >>> dv/lep_asserts.sv
// Checker for the latched memory port host controller
`timescale 1ns/1ps
`default_nettype none
module lep_asserts #(parameter PULSE_CYC = 4) (
  input wire logic mclk, sys_rst, req_valid, req_ready, rsp_valid,
  input wire logic [1:0] req_op,
  input wire logic chip_en_n, out_en_n, latch_strobe, prog_supply_en,
  input wire logic id_select_high_volt_line, byte_lines_oe,
  input wire logic [7:0] byte_lines_o);
  localparam int PD = 25 + PULSE_CYC;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_idle; req_ready && chip_en_n && out_en_n; endsequence
  chk_no_clash: assert property (byte_lines_oe |-> out_en_n)
    else $error("lines driven by both sides");
  chk_strobe_supply: assert property (prog_supply_en |-> latch_strobe)
    else $error("strobe low under supply");
  chk_addr_hold: assert property ($fell(latch_strobe) |->
    byte_lines_oe && $stable(byte_lines_o)) else $error("address moved");
  chk_mode_legal: assert property (!chip_en_n && !out_en_n |->
    !prog_supply_en) else $error("illegal mode");
  chk_id_level: assert property (id_select_high_volt_line |->
    !prog_supply_en) else $error("id with supply");
  chk_read_time: assert property (s_take ##0 (req_op != 2'h1) |->
    ##46 rsp_valid) else $error("read answer late");
  chk_prog_time: assert property (s_take ##0 (req_op == 2'h1) |->
    ##[PD:PD] rsp_valid) else $error("program answer late");
  chk_busy_hold: assert property (s_take |=>
    (!req_ready && !rsp_valid) [*8]) else $error("busy broken");
  chk_idle_after: assert property (rsp_valid |=>
    s_idle ##0 !byte_lines_oe) else $error("no idle after answer");
endmodule // lep_asserts
bind lep_host lep_asserts #(.PULSE_CYC(PULSE_CYC)) u_chk (.mclk(mclk),
  .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .req_op(req_op), .chip_en_n(chip_en_n),
  .out_en_n(out_en_n), .latch_strobe(latch_strobe),
  .prog_supply_en(prog_supply_en),
  .id_select_high_volt_line(id_select_high_volt_line),
  .byte_lines_oe(byte_lines_oe), .byte_lines_o(byte_lines_o));
`default_nettype wire

// >>> dv/lep_dev_model.sv
// Behavioural model of the latched one-time programmable memory
`timescale 1ns/1ps
`default_nettype none
// Arbitrary identification codes, each with odd parity
module lep_dev_model #(parameter [7:0] MAKER = 8'h15, DEV = 8'h2a) (
  input wire logic ce_n, oe_n, strobe, vpp, hv, hoe,
  input wire logic [14:8] ahi,
  input wire logic [7:0] hd,
  output logic [7:0] bus);
  logic [7:0] mem [0:32767];
  logic [7:0] lo;
  always @(negedge strobe) lo <= hd;
  wire [14:0] a = {ahi, (strobe || vpp) ? hd : lo};
  wire drv = !oe_n && (!ce_n || vpp);
  wire [7:0] q = hv ? (a[0] ? DEV : MAKER) : mem[a];
  always @(negedge ce_n) if (vpp && oe_n) mem[a] = hd;
  initial for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
  // Released lines show the inverse so stale data never passes
  assign bus = hoe ? hd : drv ? q : ~hd;
endmodule // lep_dev_model
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking testbench for the latched memory port host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, sys_rst, req_valid, req_ready, rsp_valid;
  logic ce_n, oe_n, stb, vpp, hv, hoe;
  logic [1:0] req_op;
  logic [14:0] req_addr, a [6];
  logic [14:8] ahi;
  logic [7:0] req_wdata, rsp_rdata, ho, bus, d [6];
  logic [7:0] exp_q [$];
  int num_errors = 0, checked = 0, seed = 32'hc189d928;
  lep_host #(.PULSE_CYC(4)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .chip_en_n(ce_n), .out_en_n(oe_n),
    .latch_strobe(stb), .prog_supply_en(vpp),
    .id_select_high_volt_line(hv), .address_hi(ahi),
    .byte_lines_o(ho), .byte_lines_oe(hoe), .byte_lines_i(bus));
  lep_dev_model u_dev (.ce_n(ce_n), .oe_n(oe_n), .strobe(stb), .vpp(vpp),
    .hv(hv), .hoe(hoe), .ahi(ahi), .hd(ho), .bus(bus));
  always #4 mclk = ~mclk;
  task automatic end_sim;
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  // Holds the request until it is taken, then notes the expected byte
  task automatic op(input logic [1:0] o, input logic [14:0] ad,
                    input logic [7:0] wd, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= ad;
    req_wdata <= wd;
    do begin
      @(negedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    if (n >= 300) begin
      num_errors++;
      end_sim();
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    exp_q.push_back(e);
  endtask
  always @(posedge mclk) if (rsp_valid === 1'b1) chk(rsp_rdata, exp_q.pop_front());
  initial begin
    int n;
    mclk = 0;
    sys_rst = 1;
    req_valid = 0;
    req_op = 0;
    req_addr = 0;
    req_wdata = 0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      d[i] = 8'($random(seed));
      // transparent latch while programming: data is the low address
      a[i] = {7'($random(seed)), d[i]};
    end
    for (int i = 5; i >= 0; i--) op(2'h1, a[i], d[i], d[i]);
    for (int i = 0; i < 6; i++) op(2'h0, a[i], 8'h00, d[i]);
    op(2'h2, a[3], 8'h00, d[3]);
    op(2'h3, 15'h0000, 8'h00, 8'h15);
    op(2'h3, 15'h0001, 8'h00, 8'h2a);
    op(2'h0, a[0] ^ 15'h5a5a, 8'h00, 8'hff);
    n = 0;
    while (exp_q.size() > 0 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 500) num_errors++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
